/* bench/adc_core_model.sv */
// Behavioural model of the conversion core that answers the sequence controller.
`timescale 1ns/10ps
module adc_core_model #(
   parameter int DELAY = 3
)(
   input  wire logic        CLOCK,
   input  wire logic        ARST_N,
   input  wire logic        CONV_START,
   input  wire logic        CONV_ABORT,
   input  wire logic        CONV_HALT,
   input  wire logic        MATCH_ALL,
   output logic             CONV_DONE,
   output logic      [11:0] CONV_RAW,
   output logic             CONV_MATCH
);
   logic [7:0]  cnt;
   logic [11:0] code;

   // The code output toggles between results so a stale value is never mistaken for a result.
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         cnt        <= 8'h00;
         code       <= 12'h5a3;
         CONV_DONE  <= 1'b0;
         CONV_RAW   <= 12'ha5c;
         CONV_MATCH <= 1'b0;
      end
      else
      begin
         CONV_DONE  <= 1'b0;
         CONV_MATCH <= 1'b0;
         CONV_RAW   <= ~CONV_RAW;
         // A restart aborts and starts in one cycle; the new start must survive the abort.
         if (CONV_START)
            cnt <= 8'(DELAY);
         else if (CONV_ABORT)
            cnt <= 8'h00;
         else if (cnt != 8'h00 && !CONV_HALT)
         begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01)
            begin
               CONV_DONE  <= 1'b1;
               CONV_RAW   <= code;
               CONV_MATCH <= MATCH_ALL;
               code       <= code + 12'h111;
            end
         end
      end
   end
endmodule

/* bench/tb_adc_sequence_control.sv */
// Self-checking testbench of the sequence controller with a core model.
`timescale 1ns/10ps
module tb_adc_sequence_control
   import adc_seq_pkg::*;
;
   logic CLOCK, ARST_N, REG_WR, REG_RD, EXT_TRIG, FREEZE_REQ, MATCH_ALL;
   logic [3:0] REG_ADDR, RES_INDEX, last_idx;
   logic [7:0] REG_WDATA, REG_RDATA, d;
   logic CONV_DONE, CONV_MATCH, CONV_START, CONV_ABORT, CONV_HALT, RES_WE;
   logic SEQ_DONE_IRQ, COMPARE_IRQ, IRQ, just_r, fifo_on;
   logic [11:0] CONV_RAW, last_raw;
   logic [15:0] RES_DATA;
   logic [3:0] idx_q[$];
   int err_count, cmp_count, res_cnt, starts, aborts, cycles, exp_n;

   adc_sequence_control dut_u (.CLOCK(CLOCK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EXT_TRIG(EXT_TRIG), .FREEZE_REQ(FREEZE_REQ),
      .CONV_DONE(CONV_DONE), .CONV_RAW(CONV_RAW), .CONV_MATCH(CONV_MATCH), .CONV_START(CONV_START),
      .CONV_ABORT(CONV_ABORT), .CONV_HALT(CONV_HALT), .RES_WE(RES_WE), .RES_INDEX(RES_INDEX),
      .RES_DATA(RES_DATA), .SEQ_DONE_IRQ(SEQ_DONE_IRQ), .COMPARE_IRQ(COMPARE_IRQ), .IRQ(IRQ));
   adc_core_model core_u (.CLOCK(CLOCK), .ARST_N(ARST_N), .CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT),
      .CONV_HALT(CONV_HALT), .MATCH_ALL(MATCH_ALL), .CONV_DONE(CONV_DONE), .CONV_RAW(CONV_RAW),
      .CONV_MATCH(CONV_MATCH));

   // ==========================================================
   // Tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      if (err_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge CLOCK);
      REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= v;
      @(posedge CLOCK);
      REG_WR <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are sampled just past that edge.
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge CLOCK);
      REG_RD <= 1'b1; REG_ADDR <= a;
      @(posedge CLOCK);
      REG_RD <= 1'b0;
      #1 v = REG_RDATA;
   endtask
   task automatic run_seq(input logic [7:0] start);
      res_cnt = 0;
      idx_q.delete();
      wr(OFS_START, start);
      repeat (400)
      begin
         @(posedge CLOCK);
         if (SEQ_DONE_IRQ === 1'b1) break;
      end
      // The last result is counted by the monitor on the edge that ended the wait.
      @(posedge CLOCK);
   endtask

   // ==========================================================
   // Clock, monitor and timeout
   initial
   begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK)
   begin
      if (CONV_DONE === 1'b1) last_raw <= CONV_RAW;
      if (CONV_START === 1'b1) starts++;
      if (CONV_ABORT === 1'b1) aborts++;
      if (fifo_on) check({15'h0, COMPARE_IRQ}, 16'h0);
      if (RES_WE === 1'b1)
      begin
         res_cnt++;
         last_idx = RES_INDEX;
         idx_q.push_back(RES_INDEX);
         check(RES_DATA, just_r ? {4'h0, last_raw} : {last_raw, 4'h0});
      end
      cycles++;
      if (cycles == 30000)
      begin
         err_count++;
         complete_run();
      end
   end

   // ==========================================================
   // Test sequence
   initial
   begin
      ARST_N = 1'b0; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 4'h0; REG_WDATA = 8'h00;
      EXT_TRIG = 1'b0; FREEZE_REQ = 1'b0; MATCH_ALL = 1'b0; just_r = 1'b0; fifo_on = 1'b0;
      err_count = 0; cmp_count = 0; res_cnt = 0; starts = 0; aborts = 0; cycles = 0;
      repeat (20) @(posedge CLOCK);
      ARST_N <= 1'b1;
      rd(OFS_SEQ_CFG, d); check({8'h0, d}, 16'h0020);
      rd(OFS_TRIG_CFG, d); check({8'h0, d}, 16'h0000);
      rd(4'hf, d); check({8'h0, d}, 16'h0000);
      // Default length with the done interrupt disabled: four results, no request.
      run_seq(8'h00);
      check(16'(res_cnt), 16'd4);
      check({15'h0, SEQ_DONE_IRQ}, 16'h0);
      wr(OFS_TRIG_CFG, 8'h02);
      wr(OFS_IRQ_MASK, 8'h03);
      for (int c = 0; c < 16; c++)
      begin
         exp_n = (c == 0 || c >= 12) ? 12 : c;
         just_r = c[0];
         wr(OFS_SEQ_CFG, {c[0], c[3:0], 3'b000});
         wr(OFS_IRQ_STAT, 8'h07);
         run_seq(8'h00);
         check({15'h0, SEQ_DONE_IRQ}, 16'h1);
         check(16'(res_cnt), 16'(exp_n));
         check({12'h0, last_idx}, 16'(exp_n - 1));
         check({12'h0, idx_q[0]}, 16'h0);
      end
      check({15'h0, IRQ}, 16'h1);
      wr(OFS_TRIG_CFG, 8'h00);
      repeat (2) @(posedge CLOCK);
      check({15'h0, SEQ_DONE_IRQ}, 16'h0);
      wr(OFS_IRQ_STAT, 8'h07);
      repeat (2) @(posedge CLOCK);
      check({15'h0, IRQ}, 16'h0);
      // Automatic compare on every conversion.
      just_r = 1'b0;
      MATCH_ALL = 1'b1;
      wr(OFS_SEQ_CFG, 8'h20);
      wr(OFS_CMP_EN, 8'hff);
      wr(OFS_CMP_EN_HI, 8'h0f);
      wr(OFS_TRIG_CFG, 8'h01);
      run_seq(8'h00);
      check({15'h0, COMPARE_IRQ}, 16'h1);
      check({15'h0, IRQ}, 16'h1);
      wr(OFS_IRQ_STAT, 8'h07);
      repeat (2) @(posedge CLOCK);
      check({14'h0, COMPARE_IRQ, IRQ}, 16'h0);
      // FIFO with continuous scanning keeps counting and wraps; compare stays off.
      wr(OFS_SEQ_CFG, 8'h24);
      fifo_on = 1'b1;
      run_seq(8'h20);
      while (idx_q.size() < 14) @(posedge CLOCK);
      for (int i = 0; i < 14; i++) check({12'h0, idx_q[i]}, 16'(i % 12));
      wr(OFS_START, 8'h20);
      // A result finishing on the restart edge still lands at its old place, so skip past it.
      repeat (2) @(posedge CLOCK);
      idx_q.delete();
      while (idx_q.size() < 1) @(posedge CLOCK);
      check({12'h0, idx_q[0]}, 16'h0);
      exp_n = aborts + 1;
      wr(OFS_SEQ_CFG, 8'h24);
      repeat (3) @(posedge CLOCK);
      check(16'(aborts), 16'(exp_n));
      rd(OFS_STATUS, d); check({12'h0, d[3:0]}, 16'h0);
      fifo_on = 1'b0;
      MATCH_ALL = 1'b0;
      // Freeze codes while scanning.
      for (int f = 0; f < 4; f++)
      begin
         wr(OFS_SEQ_CFG, {6'b010000, f[1:0]});
         wr(OFS_START, 8'h20);
         FREEZE_REQ <= 1'b1;
         repeat (30) @(posedge CLOCK);
         check({15'h0, CONV_HALT}, {15'h0, f[1]});
         FREEZE_REQ <= 1'b0;
         wr(OFS_SEQ_CFG, 8'h20);
      end
      // Trigger sense codes: inactive level first, then the active one.
      for (int m = 0; m < 4; m++)
      begin
         EXT_TRIG <= ~m[0];
         repeat (3) @(posedge CLOCK);
         wr(OFS_TRIG_CFG, {3'b000, m[1], m[0], 3'b100});
         exp_n = starts;
         wr(OFS_START, 8'h00);
         repeat (8) @(posedge CLOCK);
         check(16'(starts), 16'(exp_n));
         check({15'h0, CONV_START}, 16'h0);
         EXT_TRIG <= m[0];
         repeat (10) @(posedge CLOCK);
         check({15'h0, 1'(starts > exp_n)}, 16'h1);
         EXT_TRIG <= ~m[0];
         wr(OFS_SEQ_CFG, 8'h20);
      end
      wr(OFS_TRIG_CFG, 8'h00);
      complete_run();
   end
endmodule

/* core/adc_seq_pkg.sv */
// Package with register map, field layout, reset values and shared types of the sequence controller.
package adc_seq_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_TRIG_CFG   = 4'h2;
   localparam logic [3:0] OFS_SEQ_CFG    = 4'h3;
   localparam logic [3:0] OFS_START      = 4'h5;
   localparam logic [3:0] OFS_STATUS     = 4'h6;
   localparam logic [3:0] OFS_CMP_EN     = 4'h8;
   localparam logic [3:0] OFS_CMP_EN_HI  = 4'h9;
   localparam logic [3:0] OFS_IRQ_STAT   = 4'ha;
   localparam logic [3:0] OFS_IRQ_MASK   = 4'hb;
   // Sequence configuration fields.
   localparam int SEQ_JUSTIFY_BIT  = 7;
   localparam int SEQ_LEN_LSB      = 3;
   localparam int SEQ_FIFO_BIT     = 2;
   localparam int SEQ_FRZ_LSB      = 0;
   localparam logic [7:0] SEQ_CFG_RST   = 8'h20;
   // Trigger / interrupt-enable register fields.
   localparam int TRG_LEVEL_BIT    = 4;
   localparam int TRG_POL_BIT      = 3;
   localparam int TRG_EXT_BIT      = 2;
   localparam int TRG_SEQ_IE_BIT   = 1;
   localparam int TRG_CMP_IE_BIT   = 0;
   localparam logic [7:0] TRG_CFG_RST   = 8'h00;
   // Start register: bit 5 selects continuous scanning.
   localparam int START_SCAN_BIT   = 5;
   localparam int NUM_RESULTS      = 12;
   localparam logic [3:0] SEQ_LEN_MAX   = 4'hc;
   // Sticky event bits in the interrupt status register.
   localparam int EV_SEQ_DONE      = 0;
   localparam int EV_COMPARE       = 1;
   localparam int EV_ABORT         = 2;

   typedef enum logic [1:0] {TRG_FALL, TRG_RISE, TRG_LOW, TRG_HIGH} trig_sense_t;
   typedef enum logic [1:0] {FRZ_CONTINUE, FRZ_RESERVED, FRZ_FINISH, FRZ_NOW} freeze_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [3:0]  index;
      logic        match;
      logic [11:0] data;
   } conv_res_t;
endpackage

/* core/adc_sequence_control.sv */
// Sequence control logic of a multi-channel analog-to-digital converter.
`timescale 1ns/10ps
// Operation
// - Sequence-done interrupt requested when its enable is set and done flag sets.
// - Compare interrupt requested when enabled and a compare-enabled conversion flag sets.
// - Trigger bits decode: 00 fall, 01 rise, 10 low level, 11 high level.
// - Writing the sequence configuration register aborts the running sequence.
// - Justify bit 0 places results left, 1 places them right.
// - Results are always unsigned.
// - Four-bit length field sets conversions per sequence.
// - After reset the length field is 0100, four conversions.
// - Without FIFO mode conversion n lands in result register n.
// - With FIFO mode the result counter is not reset per sequence.
// - In FIFO scanning mode the counter wraps after the last register.
// - Status register shows the four-bit result counter.
// - Abort or start write clears the result counter, even in FIFO mode.
// - FIFO mode disables automatic compare and its interrupt entirely; a compare flag set before FIFO mode still drives IRQ.
// - Two-bit freeze field selects response to a debug breakpoint.
// - Length 1..11 binary; 0000 and 1100 upward give twelve conversions.
// - Freeze: 00 continue, 01 reserved, 10 finish then freeze, 11 freeze now.
module adc_sequence_control
   import adc_seq_pkg::*;
#(
   parameter int RES_W = 12
)(
   input  wire logic              CLOCK,
   input  wire logic              ARST_N,
   input  wire logic [ADDR_W-1:0] REG_ADDR,
   input  wire logic [7:0]        REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   output logic      [7:0]        REG_RDATA,
   input  wire logic              EXT_TRIG,
   input  wire logic              FREEZE_REQ,
   input  wire logic              CONV_DONE,
   input  wire logic [RES_W-1:0]  CONV_RAW,
   input  wire logic              CONV_MATCH,
   output logic                   CONV_START,
   output logic                   CONV_ABORT,
   output logic                   CONV_HALT,
   output logic                   RES_WE,
   output logic      [3:0]        RES_INDEX,
   output logic      [15:0]       RES_DATA,
   output logic                   SEQ_DONE_IRQ,
   output logic                   COMPARE_IRQ,
   output logic                   IRQ
);

   // =====================================================================
   // Functions
   // Length decode: zero and codes above eleven mean a full file of twelve.
   function automatic logic [3:0] seq_len_decode(input logic [3:0] code);
      if (code == 4'h0 || code > 4'hb)
         return SEQ_LEN_MAX;
      return code;
   endfunction

   // Results are unsigned codes; only their position in the word changes.
   function automatic logic [15:0] justify(input logic [RES_W-1:0] raw, input logic right);
      logic [15:0] w;
      w = 16'h0000;
      if (right)
         w[RES_W-1:0] = raw;
      else
         w[15 -: RES_W] = raw;
      return w;
   endfunction

   function automatic logic [3:0] wrap_inc(input logic [3:0] v);
      return (v == 4'(NUM_RESULTS - 1)) ? 4'h0 : v + 4'h1;
   endfunction

   // =====================================================================
   // Register file
   reg_req_t    req;
   logic [7:0]  seq_cfg_ff, nxt_seq_cfg;
   logic [7:0]  trg_cfg_ff, nxt_trg_cfg;
   logic [11:0] cmp_en_ff, nxt_cmp_en;
   logic        scan_ff, nxt_scan;
   logic [2:0]  irq_stat_ff, nxt_irq_stat;
   logic [2:0]  irq_mask_ff, nxt_irq_mask;
   logic [7:0]  rdata_ff, nxt_rdata;
   logic        fifo_mode;
   logic        cfg_write;
   logic        start_write;
   logic        abort_ev;
   logic        seq_done_ev;
   logic        cmp_ev;
   logic [11:0] conv_flag_ff, nxt_conv_flag;

   assign req         = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
   assign fifo_mode   = seq_cfg_ff[SEQ_FIFO_BIT];
   assign cfg_write   = req.wr && req.addr == OFS_SEQ_CFG;
   assign start_write = req.wr && req.addr == OFS_START;

   // =====================================================================
   // Sequencer state
   typedef enum logic [1:0] {S_IDLE, S_WAIT_TRIG, S_CONVERT, S_FROZEN} seq_state_t;
   seq_state_t state_ff, nxt_state;
   logic [3:0] res_cnt_ff, nxt_res_cnt;
   logic [3:0] seq_pos_ff, nxt_seq_pos;
   logic       trig_prev_ff, nxt_trig_prev;
   logic       start_ff, nxt_start;
   logic       abort_ff, nxt_abort;
   logic       halt_ff, nxt_halt;
   logic       res_we_ff, nxt_res_we;
   logic [3:0] res_idx_ff, nxt_res_idx;
   logic [15:0] res_data_ff, nxt_res_data;
   logic       trig_hit;
   logic [3:0] seq_len;
   freeze_t    freeze_sel;

   assign seq_len = seq_len_decode(seq_cfg_ff[SEQ_LEN_LSB +: 4]);
   assign freeze_sel     = freeze_t'(seq_cfg_ff[SEQ_FRZ_LSB +: 2]);

   always_comb
   begin
      case (trig_sense_t'({trg_cfg_ff[TRG_LEVEL_BIT], trg_cfg_ff[TRG_POL_BIT]}))
         TRG_FALL: trig_hit = trig_prev_ff && !EXT_TRIG;
         TRG_RISE: trig_hit = !trig_prev_ff && EXT_TRIG;
         TRG_LOW:  trig_hit = !EXT_TRIG;
         TRG_HIGH: trig_hit = EXT_TRIG;
         default:  trig_hit = 1'b0;
      endcase
   end

   always_comb
   begin
      nxt_state     = state_ff;
      nxt_res_cnt   = res_cnt_ff;
      nxt_seq_pos   = seq_pos_ff;
      nxt_trig_prev = EXT_TRIG;
      nxt_start     = 1'b0;
      nxt_abort     = 1'b0;
      nxt_halt      = 1'b0;
      nxt_res_we    = 1'b0;
      nxt_res_idx   = res_idx_ff;
      nxt_res_data  = res_data_ff;
      seq_done_ev   = 1'b0;
      abort_ev      = 1'b0;
      nxt_conv_flag = conv_flag_ff;
      // Freeze now halts in every state but idle; reserved code behaves as continue.
      if (FREEZE_REQ && state_ff != S_IDLE && freeze_sel == FRZ_NOW)
         nxt_halt = 1'b1;
      case (state_ff)
         S_IDLE:
            ;
         S_WAIT_TRIG:
            if (trig_hit)
            begin
               nxt_state = S_CONVERT;
               nxt_start = 1'b1;
            end
         // A done that arrives while our own start still stands belongs to an aborted conversion.
         S_CONVERT:
            if (CONV_DONE && !start_ff && !(FREEZE_REQ && freeze_sel == FRZ_NOW))
            begin
               nxt_res_we    = 1'b1;
               nxt_res_idx   = res_cnt_ff;
               nxt_res_data  = justify(CONV_RAW, seq_cfg_ff[SEQ_JUSTIFY_BIT]);
               nxt_conv_flag[res_cnt_ff] = 1'b1;
               nxt_res_cnt   = wrap_inc(res_cnt_ff);
               if (seq_pos_ff + 4'h1 >= seq_len)
               begin
                  seq_done_ev = 1'b1;
                  nxt_seq_pos = 4'h0;
                  if (!fifo_mode)
                     nxt_res_cnt = 4'h0;
                  if (scan_ff)
                     nxt_start = 1'b1;
                  else if (trg_cfg_ff[TRG_EXT_BIT])
                     nxt_state = S_WAIT_TRIG;
                  else
                     nxt_state = S_IDLE;
               end
               else
               begin
                  nxt_seq_pos = seq_pos_ff + 4'h1;
                  nxt_start   = 1'b1;
               end
               if (FREEZE_REQ && freeze_sel == FRZ_FINISH)
               begin
                  nxt_halt  = 1'b1;
                  nxt_state = S_FROZEN;
               end
            end
            else if (FREEZE_REQ && freeze_sel == FRZ_FINISH)
               nxt_halt = 1'b0;
         S_FROZEN:
            if (!FREEZE_REQ)
            begin
               nxt_state = (seq_pos_ff == 4'h0 && !scan_ff) ? S_IDLE : S_CONVERT;
               nxt_start = nxt_state == S_CONVERT;
            end
            else
               nxt_halt = 1'b1;
         default:
            nxt_state = S_IDLE;
      endcase
      if (cfg_write || start_write)
      begin
         abort_ev    = cfg_write && state_ff != S_IDLE;
         nxt_abort   = state_ff != S_IDLE;
         nxt_res_cnt = 4'h0;
         nxt_seq_pos = 4'h0;
         nxt_halt    = 1'b0;
         nxt_start   = 1'b0;
         nxt_state   = S_IDLE;
         if (start_write)
         begin
            nxt_conv_flag = 12'h000;
            if (trg_cfg_ff[TRG_EXT_BIT])
               nxt_state = S_WAIT_TRIG;
            else
            begin
               nxt_state = S_CONVERT;
               nxt_start = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         state_ff     <= S_IDLE;
         res_cnt_ff   <= 4'h0;
         seq_pos_ff   <= 4'h0;
         trig_prev_ff <= 1'b0;
         start_ff     <= 1'b0;
         abort_ff     <= 1'b0;
         halt_ff      <= 1'b0;
         res_we_ff    <= 1'b0;
         res_idx_ff   <= 4'h0;
         res_data_ff  <= 16'h0000;
         conv_flag_ff <= 12'h000;
      end
      else
      begin
         state_ff     <= nxt_state;
         res_cnt_ff   <= nxt_res_cnt;
         seq_pos_ff   <= nxt_seq_pos;
         trig_prev_ff <= nxt_trig_prev;
         start_ff     <= nxt_start;
         abort_ff     <= nxt_abort;
         halt_ff      <= nxt_halt;
         res_we_ff    <= nxt_res_we;
         res_idx_ff   <= nxt_res_idx;
         res_data_ff  <= nxt_res_data;
         conv_flag_ff <= nxt_conv_flag;
      end
   end

   // =====================================================================
   // Compare and interrupts
   // FIFO mode masks both the compare enable and every per-conversion enable.
   assign cmp_ev = CONV_DONE && !start_ff && state_ff == S_CONVERT && CONV_MATCH && !fifo_mode
                   && cmp_en_ff[seq_pos_ff] && trg_cfg_ff[TRG_CMP_IE_BIT];

   always_comb
   begin
      nxt_seq_cfg  = seq_cfg_ff;
      nxt_trg_cfg  = trg_cfg_ff;
      nxt_cmp_en   = cmp_en_ff;
      nxt_scan     = scan_ff;
      nxt_irq_mask = irq_mask_ff;
      nxt_irq_stat = irq_stat_ff;
      nxt_rdata    = 8'h00;
      if (req.wr)
         case (req.addr)
            OFS_SEQ_CFG:   nxt_seq_cfg = req.wdata;
            OFS_TRIG_CFG:  nxt_trg_cfg = req.wdata & 8'h1f;
            OFS_START:     nxt_scan = req.wdata[START_SCAN_BIT];
            OFS_CMP_EN:    nxt_cmp_en[7:0] = req.wdata;
            OFS_CMP_EN_HI: nxt_cmp_en[11:8] = req.wdata[3:0];
            OFS_IRQ_STAT:  nxt_irq_stat = irq_stat_ff & ~req.wdata[2:0];
            OFS_IRQ_MASK:  nxt_irq_mask = req.wdata[2:0];
            default:       ;
         endcase
      // Hardware set wins over a same-cycle clear.
      if (seq_done_ev && trg_cfg_ff[TRG_SEQ_IE_BIT])
         nxt_irq_stat[EV_SEQ_DONE] = 1'b1;
      if (cmp_ev)
         nxt_irq_stat[EV_COMPARE] = 1'b1;
      if (abort_ev)
         nxt_irq_stat[EV_ABORT] = 1'b1;
      if (req.rd)
         case (req.addr)
            OFS_SEQ_CFG:   nxt_rdata = seq_cfg_ff;
            OFS_TRIG_CFG:  nxt_rdata = trg_cfg_ff;
            OFS_START:     nxt_rdata = {2'b00, scan_ff, 5'h00};
            OFS_STATUS:    nxt_rdata = {state_ff != S_IDLE, 3'b000, res_cnt_ff};
            OFS_CMP_EN:    nxt_rdata = cmp_en_ff[7:0];
            OFS_CMP_EN_HI: nxt_rdata = {4'h0, cmp_en_ff[11:8]};
            OFS_IRQ_STAT:  nxt_rdata = {5'h00, irq_stat_ff};
            OFS_IRQ_MASK:  nxt_rdata = {5'h00, irq_mask_ff};
            default:       nxt_rdata = 8'h00;
         endcase
   end

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         seq_cfg_ff  <= SEQ_CFG_RST;
         trg_cfg_ff  <= TRG_CFG_RST;
         cmp_en_ff   <= 12'h000;
         scan_ff     <= 1'b0;
         irq_stat_ff <= 3'h0;
         irq_mask_ff <= 3'h0;
         rdata_ff    <= 8'h00;
         SEQ_DONE_IRQ <= 1'b0;
         COMPARE_IRQ  <= 1'b0;
         IRQ          <= 1'b0;
      end
      else
      begin
         seq_cfg_ff  <= nxt_seq_cfg;
         trg_cfg_ff  <= nxt_trg_cfg;
         cmp_en_ff   <= nxt_cmp_en;
         scan_ff     <= nxt_scan;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         rdata_ff    <= nxt_rdata;
         // Requests drop as soon as the enable or the flag drops.
         SEQ_DONE_IRQ <= nxt_irq_stat[EV_SEQ_DONE] && nxt_trg_cfg[TRG_SEQ_IE_BIT];
         COMPARE_IRQ  <= nxt_irq_stat[EV_COMPARE] && nxt_trg_cfg[TRG_CMP_IE_BIT]
                         && !nxt_seq_cfg[SEQ_FIFO_BIT];
         IRQ          <= |(nxt_irq_stat & nxt_irq_mask);
      end
   end

   assign REG_RDATA  = rdata_ff;
   assign CONV_START = start_ff;
   assign CONV_ABORT = abort_ff;
   assign CONV_HALT  = halt_ff;
   assign RES_WE     = res_we_ff;
   assign RES_INDEX  = res_idx_ff;
   assign RES_DATA   = res_data_ff;

   // =====================================================================
   // Checks
   AST_ABORT_ON_CFG: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      cfg_write && state_ff != S_IDLE |=> CONV_ABORT && state_ff == S_IDLE)
      else $error("config write did not abort");
   AST_CNT_CLEAR: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (cfg_write || start_write) |=> res_cnt_ff == 4'h0)
      else $error("result counter not cleared");
   AST_CNT_WRAP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      RES_WE |-> RES_INDEX < 4'(NUM_RESULTS))
      else $error("result index out of file");
   AST_NONFIFO_POS: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      !fifo_mode && state_ff == S_CONVERT |-> res_cnt_ff == seq_pos_ff)
      else $error("non-FIFO result index mismatch");
   AST_FIFO_NO_CMP: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      fifo_mode |=> !COMPARE_IRQ)
      else $error("compare interrupt in FIFO mode");
   AST_SEQ_IRQ: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      seq_done_ev && trg_cfg_ff[TRG_SEQ_IE_BIT] && !req.wr |=> SEQ_DONE_IRQ)
      else $error("sequence interrupt missing");
   AST_IRQ_AND: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      SEQ_DONE_IRQ |-> trg_cfg_ff[TRG_SEQ_IE_BIT] && irq_stat_ff[EV_SEQ_DONE])
      else $error("sequence interrupt without enable");
   AST_LEN_RANGE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      seq_len >= 4'h1 && seq_len <= SEQ_LEN_MAX)
      else $error("sequence length out of range");
   AST_FRZ_NOW: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      FREEZE_REQ && freeze_sel == FRZ_NOW && state_ff == S_CONVERT && !req.wr |=> !RES_WE)
      else $error("result written while frozen");
   COV_SEQ_DONE: cover property (@(posedge CLOCK) disable iff (!ARST_N) seq_done_ev);
   COV_FIFO_WRAP: cover property (@(posedge CLOCK) disable iff (!ARST_N)
      fifo_mode && RES_WE && RES_INDEX == 4'hb);
   COV_ABORT: cover property (@(posedge CLOCK) disable iff (!ARST_N) CONV_ABORT);
   COV_CMP: cover property (@(posedge CLOCK) disable iff (!ARST_N) COMPARE_IRQ);

endmodule
